// *** design/purs_sequencer.v ***
// power-up reset sequencer: startup clock, reset release and pin defaults
//
// Behaviour
// - All logic except the input and pin synchronisers stays in its initial state until power is stable.
// - Generator zero runs from the 8 MHz oscillator divided by eight.
// - Generator zero clocks the power manager once startup ticks run.
// - A default set of system clocks runs after startup for software.
// - Default system clocks divide by one and see the 1 MHz clock.
// - At reset exit only the watchdog generic clock channel is on.
// - Every general-purpose pin stays tri-stated until software sets it.
// - On release the processor fetches its vectors from address zero.
// - A detected debugger hands the debug data pin to its function.
// - Of the two debug pins only the clock pin always goes through the function multiplexer.
// - Function B on a pin removes its digital input and output control, except on the debug data pin while a debugger is attached.
// - Crystal pin muxing follows the system controller, not the mux.
// - The regulator has a normal mode and a low-power standby mode.
// - The power-on monitor never sleeps and resets all but the synchronisers on low supply.
`timescale 1ns/100ps
`include "purs_map.vh"
module purs_sequencer (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        power_stable,
   input  wire        analog_supply_ok,
   input  wire        debugger_detect,
   input  wire        standby_req,
   input  wire        sw_cfg_valid,
   input  wire [7:0]  sw_clk_enable,
   input  wire [7:0]  sw_pin_oe_n,
   input  wire [7:0]  sw_pin_out,
   input  wire [31:0] sw_pin_func,
   input  wire [7:0]  pin_in,
   input  wire        xosc_pin_select,
   input  wire        debug_data_drive,
   input  wire        debug_data_out,
   input  wire        debug_clk_func_sel,
   output reg         startup_clk_en,
   output reg         power_manager_clk_en,
   output reg         system_rst_n,
   output reg  [7:0]  sys_clk_div,
   output reg  [7:0]  sys_clk_run,
   output reg  [7:0]  generic_clock_generator_chan_en,
   output reg  [31:0] boot_fetch_addr,
   output reg         boot_fetch_start,
   output wire [7:0]  pin_out,
   output wire [7:0]  pin_oe_n,
   output wire [7:0]  pin_in_digital,
   output reg         debug_data_active,
   output wire        debug_clk_via_mux,
   output reg         xosc_pins_owned,
   output reg         regulator_mode
);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   // three stages each; a change counts once stages two and three agree
   reg [2:0] pwr_sync_reg;
   reg [2:0] ana_sync_reg;
   reg [2:0] dbg_sync_reg;
   reg       pwr_ok_reg;
   reg       ana_ok_reg;
   reg       dbg_ok_reg;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         pwr_sync_reg <= 3'h0;
         ana_sync_reg <= 3'h0;
         dbg_sync_reg <= 3'h0;
         pwr_ok_reg   <= 1'b0;
         ana_ok_reg   <= 1'b0;
         dbg_ok_reg   <= 1'b0;
      end else begin
         pwr_sync_reg <= {pwr_sync_reg[1:0], power_stable};
         ana_sync_reg <= {ana_sync_reg[1:0], analog_supply_ok};
         dbg_sync_reg <= {dbg_sync_reg[1:0], debugger_detect};
         if (pwr_sync_reg[1] == pwr_sync_reg[2])
            pwr_ok_reg <= pwr_sync_reg[2];
         if (ana_sync_reg[1] == ana_sync_reg[2])
            ana_ok_reg <= ana_sync_reg[2];
         if (dbg_sync_reg[1] == dbg_sync_reg[2])
            dbg_ok_reg <= dbg_sync_reg[2];
      end
   end

   // the monitor never sleeps: a low supply always pulls the chip back
   wire supply_good = pwr_ok_reg & ana_ok_reg;

   // pin levels are asynchronous as well; three stages per pin here,
   // the agreement filter sits in the per-pin logic further down
   // (the first stage feeds only the second, never any decision)
   reg [7:0] pin_s1_reg;
   reg [7:0] pin_s2_reg;
   reg [7:0] pin_s3_reg;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         pin_s1_reg <= 8'h00;
         pin_s2_reg <= 8'h00;
         pin_s3_reg <= 8'h00;
      end else begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // ==========================================================
   // startup clock divider
   // ==========================================================
   // divide by eight; a one-cycle enable marks each 1 MHz rising edge
   // the count restarts on supply loss, so the first tick after a dip
   // is a full startup period late rather than a runt
   reg [3:0] div_cnt_reg;
   wire      div_wrap = (div_cnt_reg == `PURS_OSC_DIV - 4'h1);

   always @(posedge core_clk) begin
      if (!rst_n || !supply_good) begin
         div_cnt_reg    <= 4'h0;
         startup_clk_en <= 1'b0;
      end else begin
         div_cnt_reg    <= div_wrap ? 4'h0 : div_cnt_reg + 4'h1;
         startup_clk_en <= div_wrap;
      end
   end

   // ==========================================================
   // sequencer state machine
   // ==========================================================
   // hold waits for the first startup tick, clkrun counts further ticks,
   // release is a single cycle that lets go of the system reset, and run
   // stays until power or the reset input is lost; only a reset leaves run
   // so a glitch on a software input can never restart the sequence
   localparam ST_HOLD    = 4'b0001;
   localparam ST_CLKRUN  = 4'b0010;
   localparam ST_RELEASE = 4'b0100;
   localparam ST_RUN     = 4'b1000;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [3:0] rel_cnt_reg;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:    if (startup_clk_en) state_next = ST_CLKRUN;
         ST_CLKRUN:  if (startup_clk_en &&
                         rel_cnt_reg == `PURS_REL_CYCLES)
                        state_next = ST_RELEASE;
         ST_RELEASE: state_next = ST_RUN;
         ST_RUN:     state_next = ST_RUN;
         default:    state_next = ST_HOLD;
      endcase
   end

   // release counts startup clock edges so reset leaves on a clean edge
   always @(posedge core_clk) begin
      if (!rst_n || !supply_good) begin
         state_reg   <= ST_HOLD;
         rel_cnt_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_CLKRUN && startup_clk_en)
            rel_cnt_reg <= rel_cnt_reg + 4'h1;
      end
   end

   // ==========================================================
   // clock tree and reset outputs
   // ==========================================================
   // only the watchdog channel survives reset exit; software may open
   // more channels later through the load strobe
   wire [7:0] generic_clock_generator_default;
   genvar gc;
   generate
      for (gc = 0; gc < `PURS_GENERIC_CLOCK_GENERATOR_CHANNELS; gc = gc + 1) begin : g_generic_clock_generator
         assign generic_clock_generator_default[gc] = (gc == `PURS_WDT_CHANNEL);
      end
   endgenerate

   always @(posedge core_clk) begin
      if (!rst_n || !supply_good) begin
         power_manager_clk_en <= 1'b0;
         system_rst_n         <= 1'b0;
         sys_clk_div          <= `PURS_SYS_DIV;
         sys_clk_run          <= 8'h00;
         generic_clock_generator_chan_en         <= 8'h00;
         boot_fetch_addr      <= `PURS_RESET_ADDR;
         boot_fetch_start     <= 1'b0;
      end else begin
         // the fetch strobe lasts one cycle; it only rises at release
         boot_fetch_start <= 1'b0;
         // power manager rides generator zero once the clock runs
         if (state_reg != ST_HOLD)
            power_manager_clk_en <= 1'b1;
         // release lands two clocks after the last startup clock tick
         if (state_reg == ST_RELEASE) begin
            system_rst_n     <= 1'b1;
            sys_clk_run      <= 8'hFF;
            sys_clk_div      <= `PURS_SYS_DIV;
            generic_clock_generator_chan_en     <= generic_clock_generator_default;
            boot_fetch_addr  <= `PURS_RESET_ADDR;
            boot_fetch_start <= 1'b1;
         end else if (state_reg == ST_RUN && sw_cfg_valid) begin
            generic_clock_generator_chan_en <= sw_clk_enable;
         end
      end
   end

   // ==========================================================
   // pin control
   // ==========================================================
   // software settings only apply once running; until then pins float
   // (a load offered while still in reset is dropped, not queued)
   reg [7:0] pin_oe_n_reg;
   reg [7:0] pin_out_reg;
   always @(posedge core_clk) begin
      if (!rst_n || !supply_good) begin
         pin_oe_n_reg <= 8'hFF;
         pin_out_reg  <= 8'h00;
      end else if (state_reg == ST_RUN && sw_cfg_valid) begin
         pin_oe_n_reg <= sw_pin_oe_n;
         pin_out_reg  <= sw_pin_out;
      end
   end

   // analog function B cuts digital control per pin; the last pin is the
   // debug data pin, which bypasses the multiplexer while a debugger is attached
   // every pin output leaves from a flip-flop, so a function change shows
   // one clock later but can never glitch the pad; the input side adds
   // the synchroniser latency on top, which software must allow for
   genvar gi;
   generate
      for (gi = 0; gi < `PURS_PIN_COUNT; gi = gi + 1) begin : g_pin
         wire analog_sel = (sw_pin_func[gi*4 +: 4] == `PURS_FUNC_B);
         wire oe_n_next;
         wire out_next;
         wire din_next;
         reg  in_ok_reg;
         reg  oe_n_reg;
         reg  out_reg;
         reg  din_reg;

         if (gi == `PURS_PIN_COUNT - 1) begin : g_dbg
            // the debugger owns the pad outright while it is attached
            assign oe_n_next = debug_data_active ?
                               ~debug_data_drive :
                               (pin_oe_n_reg[gi] | analog_sel);
            assign out_next  = debug_data_active ? debug_data_out :
                               (pin_out_reg[gi] & ~analog_sel);
            assign din_next  = in_ok_reg &
                               (debug_data_active | ~analog_sel);
         end else begin : g_gpio
            assign oe_n_next = pin_oe_n_reg[gi] | analog_sel;
            assign out_next  = pin_out_reg[gi] & ~analog_sel;
            assign din_next  = in_ok_reg & ~analog_sel;
         end

         // a pin level counts once stages two and three agree
         always @(posedge core_clk) begin
            if (!rst_n || !supply_good) begin
               in_ok_reg <= 1'b0;
               oe_n_reg  <= 1'b1;
               out_reg   <= 1'b0;
               din_reg   <= 1'b0;
            end else begin
               if (pin_s2_reg[gi] == pin_s3_reg[gi])
                  in_ok_reg <= pin_s3_reg[gi];
               oe_n_reg <= oe_n_next;
               out_reg  <= out_next;
               din_reg  <= din_next;
            end
         end

         assign pin_oe_n[gi]       = oe_n_reg;
         assign pin_out[gi]        = out_reg;
         assign pin_in_digital[gi] = din_reg;
      end
   endgenerate

   // debug clock is an ordinary mux function; data pin is not
   assign debug_clk_via_mux = debug_clk_func_sel;

   // ==========================================================
   // debugger, crystal pins and regulator mode
   // ==========================================================
   always @(posedge core_clk) begin
      if (!rst_n || !supply_good) begin
         debug_data_active <= 1'b0;
         xosc_pins_owned   <= 1'b0;
         regulator_mode    <= `PURS_REG_NORMAL;
      end else begin
         // presence is already filtered, so a bouncing connector cannot
         // toggle the owner of the data pin from cycle to cycle
         debug_data_active <= dbg_ok_reg;
         xosc_pins_owned   <= xosc_pin_select;
         // low power only while in standby and running
         regulator_mode    <= (state_reg == ST_RUN && standby_req) ?
                              `PURS_REG_LOWPWR : `PURS_REG_NORMAL;
      end
   end

endmodule

// *** design/purs_map.vh ***
// constants for the power-up reset sequencer
`ifndef PURS_MAP_VH
`define PURS_MAP_VH
// startup divider: 8 MHz oscillator divided by eight
`define PURS_OSC_DIV        4'h8
`define PURS_OSC_HALF       4'h4
// reset stretch in startup clock periods
`define PURS_REL_CYCLES     4'h4
// default system clock divide ratio
`define PURS_SYS_DIV        8'h01
// generic clock channels and the watchdog channel index
`define PURS_GENERIC_CLOCK_GENERATOR_CHANNELS  8
`define PURS_WDT_CHANNEL    0
// reset vector address
`define PURS_RESET_ADDR     32'h00000000
// pin count and analog function code
`define PURS_PIN_COUNT      8
`define PURS_FUNC_B         4'h1
// regulator modes
`define PURS_REG_NORMAL     1'b0
`define PURS_REG_LOWPWR     1'b1
`endif

// *** dv/purs_supply_model.sv ***
// supply monitor model feeding the power-good inputs of the sequencer
`timescale 1ns/100ps
module purs_supply_model (
   input  wire power_on,
   input  wire brown_out,
   output reg  power_stable,
   output wire analog_supply_ok
);
   // ==========================================================
   // supplies
   // rails settle some time after switch-on, not at once
   initial power_stable = 1'b0;
   always @(power_on) power_stable <= #50 power_on;
   // analog monitor drops at once on a brown-out
   assign analog_supply_ok = power_on & ~brown_out;
endmodule

// *** dv/purs_sequencer_checker.sv ***
// assertions on the ports of the power-up reset sequencer
`timescale 1ns/100ps
module purs_sequencer_checker (
   input wire        core_clk,
   input wire        rst_n,
   input wire [31:0] sw_pin_func,
   input wire        debug_clk_func_sel,
   input wire        startup_clk_en,
   input wire        power_manager_clk_en,
   input wire        system_rst_n,
   input wire [7:0]  sys_clk_div,
   input wire [7:0]  sys_clk_run,
   input wire [7:0]  generic_clock_generator_chan_en,
   input wire [31:0] boot_fetch_addr,
   input wire        boot_fetch_start,
   input wire [7:0]  pin_oe_n,
   input wire [7:0]  pin_in_digital,
   input wire        debug_clk_via_mux
);
   // ==========================================================
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_rst_held: assert property (
      !power_manager_clk_en |-> !system_rst_n)
      else $error("system reset released before startup clock");
   a_div_period: assert property (
      startup_clk_en |=> !startup_clk_en [*7])
      else $error("startup tick closer than eight clocks");
   a_pm_clk_on: assert property (
      system_rst_n |-> power_manager_clk_en)
      else $error("power manager clock off while running");
   a_release_defaults: assert property (
      $rose(system_rst_n) |-> generic_clock_generator_chan_en == 8'h01 &&
      sys_clk_run == 8'hFF && boot_fetch_start)
      else $error("wrong clock defaults at release");
   a_div_one: assert property (sys_clk_div == 8'h01)
      else $error("system clock divide not one");
   a_boot_addr: assert property (
      boot_fetch_start |-> boot_fetch_addr == 32'h00000000 ##1
      !boot_fetch_start)
      else $error("bad boot fetch");
   a_rel_sync: assert property (
      $rose(system_rst_n) |->
      $past(startup_clk_en) || $past(startup_clk_en, 2))
      else $error("release not on a startup tick");
   a_tristate_reset: assert property (
      !system_rst_n |-> pin_oe_n == 8'hFF)
      else $error("pin driven during reset");
   a_func_b_gate: assert property (
      sw_pin_func[3:0] == 4'h1 |=> !pin_in_digital[0] && pin_oe_n[0])
      else $error("analog pin keeps digital control");
   a_dbg_clk_mux: assert property (
      debug_clk_via_mux == debug_clk_func_sel)
      else $error("debug clock not through mux");
   c_boot: cover property (boot_fetch_start);
   c_loss: cover property ($fell(system_rst_n));
   c_func_b: cover property (sw_pin_func[3:0] == 4'h1);
endmodule
bind purs_sequencer purs_sequencer_checker u_purs_sequencer_checker (.*);

// *** dv/test_power_up_reset_sequencer.sv ***
// self-checking bench for the power-up reset sequencer
`timescale 1ns/100ps
module test_power_up_reset_sequencer;
   reg core_clk = 1'b0, rst_n = 1'b0, power_on = 1'b0, brown_out = 1'b0;
   reg debugger_detect = 1'b0, standby_req = 1'b0, sw_cfg_valid = 1'b0;
   reg xosc_pin_select = 1'b0, debug_data_drive = 1'b0;
   reg debug_data_out = 1'b0, debug_clk_func_sel = 1'b0;
   reg [7:0] sw_clk_enable = 8'h00, sw_pin_oe_n = 8'hFF;
   reg [7:0] sw_pin_out = 8'h00, pin_in = 8'h00;
   reg [31:0] sw_pin_func = 32'h00000000;
   wire power_stable, analog_supply_ok, startup_clk_en, power_manager_clk_en;
   wire system_rst_n, boot_fetch_start, debug_data_active, debug_clk_via_mux;
   wire xosc_pins_owned, regulator_mode;
   wire [7:0] sys_clk_div, sys_clk_run, generic_clock_generator_chan_en, pin_out, pin_oe_n;
   wire [7:0] pin_in_digital;
   wire [31:0] boot_fetch_addr;
   integer n_errors = 0, checks = 0, p;
   purs_supply_model u_purs_supply_model (.*);
   purs_sequencer u_purs_sequencer (.*);
   initial forever #5 core_clk = ~core_clk;
   // ==========================================================
   // shared tasks
   task finish_test;
      begin
         $display("errors %0d checks %0d", n_errors, checks);
         if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task nclk(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   // bounded wait for release, counting startup ticks and their spacing
   task wait_rel(output integer pulses);
      integer i, gap;
      begin
         pulses = 0;
         gap = 0;
         for (i = 0; i < 300 && system_rst_n !== 1'b1; i = i + 1) begin
            nclk(1);
            if (startup_clk_en === 1'b1) begin
               if (pulses > 0) chk(gap, 8);
               pulses = pulses + 1;
               gap = 0;
            end
            gap = gap + 1;
         end
         if (system_rst_n !== 1'b1) begin
            n_errors = n_errors + 1;
            finish_test;
         end
      end
   endtask
   // ==========================================================
   // scenarios
   task t_power_up;
      begin
         sw_pin_oe_n = 8'h00; // offered before run, must be ignored
         sw_cfg_valid = 1'b1;
         nclk(3);
         chk(system_rst_n, 0);
         chk(sys_clk_run, 8'h00);
         sw_cfg_valid = 1'b0;
         power_on = 1'b1;
         wait_rel(p);
         chk(p, 6);
         chk(power_manager_clk_en, 1);
         chk(generic_clock_generator_chan_en, 8'h01);
         chk(sys_clk_run, 8'hFF);
         chk(sys_clk_div, 8'h01);
         chk(boot_fetch_start, 1);
         chk(boot_fetch_addr, 32'h00000000);
         chk(pin_oe_n, 8'hFF);
      end
   endtask
   task t_pins;
      begin
         sw_pin_out = 8'hA5;
         sw_clk_enable = 8'h03;
         sw_cfg_valid = 1'b1;
         nclk(1);
         sw_cfg_valid = 1'b0;
         nclk(1);
         chk(pin_oe_n, 8'h00);
         chk(pin_out, 8'hA5);
         chk(generic_clock_generator_chan_en, 8'h03);
         pin_in = 8'hFF;
         sw_pin_func = 32'h00000001;
         nclk(5);
         chk(pin_in_digital, 8'hFE);
         chk(pin_oe_n, 8'h01);
         sw_pin_func = 32'h00000000;
      end
   endtask
   task t_debug;
      begin
         debugger_detect = 1'b1;
         xosc_pin_select = 1'b1;
         debug_clk_func_sel = 1'b1;
         debug_data_drive = 1'b1;
         nclk(6);
         chk(debug_data_active, 1);
         chk(pin_out[7], 0);
         chk(pin_oe_n[7], 0);
         chk(xosc_pins_owned, 1);
         chk(debug_clk_via_mux, 1);
         debugger_detect = 1'b0;
         nclk(6);
         chk(debug_data_active, 0);
         standby_req = 1'b1;
         nclk(2);
         chk(regulator_mode, 1);
         standby_req = 1'b0;
         nclk(2);
         chk(regulator_mode, 0);
      end
   endtask
   task t_brownout;
      begin
         brown_out = 1'b1;
         nclk(8);
         chk(system_rst_n, 0);
         chk(generic_clock_generator_chan_en, 8'h00);
         chk(pin_oe_n, 8'hFF);
         brown_out = 1'b0;
         wait_rel(p);
         chk(p, 6);
      end
   endtask
   initial begin
      nclk(20);
      rst_n = 1'b1;
      t_power_up;
      t_pins;
      t_debug;
      t_brownout;
      finish_test;
   end
endmodule
